// File: core/lfafe_pkg.sv
package lfafe_pkg;
	// clock and derived cycle counts
	localparam int CLK_HZ = 40_000_000;
	localparam int IDLE_TIMEOUT_US = 16000;
	localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int MS_US = 1000;
	localparam int MS_CYCLES = MS_US * (CLK_HZ / 1_000_000);
	localparam int MOD_PULSE_NS = 1000;
	localparam int MOD_PULSE_CYCLES = (MOD_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// serial frame: command, register index, data, msb first
	localparam int CMD_W = 3;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 9;
	localparam int HDR_BITS = CMD_W + ADDR_W;
	localparam int FRAME_BITS = HDR_BITS + DATA_W;
	localparam logic [3:0] HDR_LAST = 4'h5;
	localparam logic [3:0] FRAME_LAST = 4'he;

	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_CLAMP_ON = 3'b001,
		CMD_CLAMP_OFF = 3'b010,
		CMD_SOFT_RESET = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_READ = 3'b101
	} lfafe_cmd_t;

	// register indices
	localparam logic [2:0] REG_CHAN = 3'h0;
	localparam logic [2:0] REG_OUT = 3'h1;
	localparam logic [2:0] REG_TUNE_Y = 3'h2;
	localparam logic [2:0] REG_TUNE_Z = 3'h3;
	localparam logic [2:0] REG_SENS_XY = 3'h4;
	localparam logic [2:0] REG_AUTO = 3'h5;
	localparam logic [2:0] REG_COLPAR = 3'h6;
	localparam logic [2:0] REG_STATUS = 3'h7;
	localparam int NUM_CFG = 7;

	// field positions
	localparam int F_PARITY = 0;
	localparam int F_CHEN_HI = 8;
	localparam int F_CHEN_LO = 6;
	localparam int F_OEH_HI = 5;
	localparam int F_OEH_LO = 4;
	localparam int F_OEL_HI = 3;
	localparam int F_OEL_LO = 2;
	localparam int F_OUT_HI = 8;
	localparam int F_OUT_LO = 7;
	localparam int F_TUNE_HI = 6;
	localparam int F_TUNE_LO = 1;
	localparam int F_SENSA_HI = 8;
	localparam int F_SENSA_LO = 5;
	localparam int F_SENSB_HI = 4;
	localparam int F_SENSB_LO = 1;
	localparam int F_AUTO = 8;

	// reset values
	localparam logic [8:0] RST_CHAN = 9'h1c0;
	localparam logic [8:0] RST_CFG = 9'h000;

	// output type codes
	localparam logic [1:0] OUT_DEMOD = 2'h0;
	localparam logic [1:0] OUT_CARRIER = 2'h1;
	localparam logic [1:0] OUT_RSSI = 2'h2;

	typedef enum logic [1:0] {
		OEF_WAIT = 2'b00,
		OEF_HIGH = 2'b01,
		OEF_LOW = 2'b10,
		OEF_PASS = 2'b11
	} lfafe_oef_t;
endpackage

// File: core/lfafe_spi.sv
`timescale 1ns/100ps
module lfafe_spi import lfafe_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdio_i,
	input wire logic [8:0] rd_data,
	output logic [2:0] rd_addr,
	output logic cmd_valid,
	output lfafe_cmd_t cmd,
	output logic [2:0] addr,
	output logic [8:0] wdata,
	output logic sdio_o,
	output logic sdio_oe
);
	logic sclk_q, sclk_d;
	logic [3:0] cnt_q, cnt_d;
	logic [FRAME_BITS-1:0] sh_q, sh_d;
	logic [8:0] tx_q, tx_d;
	logic oe_q, oe_d, load_q, load_d, vld_q, vld_d;
	logic rise, fall;

	// shift in on rising sclk, shift read data out after falling sclk
	always_comb begin
		sclk_d = sclk;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		oe_d = oe_q;
		load_d = 1'b0;
		vld_d = 1'b0;
		rise = sclk & ~sclk_q;
		fall = ~sclk & sclk_q;
		if (cs_n) begin
			// chip select high aborts any partial frame
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else begin
			if (load_q) begin
				tx_d = rd_data;
				oe_d = 1'b1;
			end
			if (fall && oe_q) begin
				tx_d = {tx_q[7:0], 1'b0};
			end
			if (rise) begin
				sh_d = {sh_q[FRAME_BITS-2:0], sdio_i};
				cnt_d = cnt_q + 4'h1;
				// command bits sit above the two index bits already shifted in
				if (cnt_q == HDR_LAST && sh_q[HDR_BITS-2:ADDR_W-1] == CMD_READ) begin
					load_d = 1'b1;
				end
				if (cnt_q == FRAME_LAST) begin
					cnt_d = 4'h0;
					oe_d = 1'b0;
					vld_d = (sh_q[FRAME_BITS-2:FRAME_BITS-4] != CMD_READ);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= '0;
			tx_q <= 9'h000;
			oe_q <= 1'b0;
			load_q <= 1'b0;
			vld_q <= 1'b0;
		end else if (clk_en) begin
			sclk_q <= sclk_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			oe_q <= oe_d;
			load_q <= load_d;
			vld_q <= vld_d;
		end
	end

	// frame fields are read straight from the shifter
	assign rd_addr = sh_q[ADDR_W-1:0];
	assign cmd_valid = vld_q;
	assign cmd = lfafe_cmd_t'(sh_q[FRAME_BITS-1:FRAME_BITS-CMD_W]);
	assign addr = sh_q[DATA_W+ADDR_W-1:DATA_W];
	assign wdata = sh_q[DATA_W-1:0];
	assign sdio_o = tx_q[8];
	assign sdio_oe = oe_q;
endmodule // lfafe_spi

// File: core/lfafe_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - seven config registers plus status, nine bits
// - status register is read only
// - clamp commands switch modulation transistors
// - clamp acts only on enabled channels
// - modulation pulse after every soft reset
// - six-bit tuning value per channel
// - four-bit desensitise value per channel
// - register five bit eight enables auto pick
// - sample channels at settle end, block lows
// - status bits eight to six show pick
// - soft reset clears auto pick state
// - blocking only on demodulated data output
// - carrier clock on pin when selected
// - OR of channel data feeds filter
// - filter gates data until wake sequence
// - pin is serial data while select low
// - sixteen ms idle issues soft reset
module lfafe_ctrl import lfafe_pkg::*; #(
	parameter int IDLE_CYCLES = IDLE_TIMEOUT_CYCLES,
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic pin_i,
	input wire logic [2:0] demod_ch,
	input wire logic carrier_in,
	input wire logic gain_settled,
	output logic pin_o,
	output logic pin_oe,
	output logic [2:0] modulation_on,
	output logic [2:0] channel_enable,
	output logic [5:0] tune_x,
	output logic [5:0] tune_y,
	output logic [5:0] tune_z,
	output logic [3:0] sens_x,
	output logic [3:0] sens_y,
	output logic [3:0] sens_z,
	output logic [1:0] output_type_select,
	output logic auto_channel_pick_enable,
	output logic soft_reset_pulse
);
	localparam int IW = $clog2(IDLE_CYCLES + 1);
	localparam int PW = $clog2(MS_TICK_CYCLES + 1);
	localparam int MW = $clog2(MOD_PULSE_CYCLES + 1);

	// filter minimum times in ms from a two-bit code
	function automatic logic [3:0] oe_min_ms(input logic [1:0] code);
		unique case (code)
			2'h0: oe_min_ms = 4'h1;
			2'h1: oe_min_ms = 4'h1;
			2'h2: oe_min_ms = 4'h2;
			2'h3: oe_min_ms = 4'h4;
		endcase
	endfunction

	// longest allowed pulse or gap: both minima plus one, plus two from six ms up
	function automatic logic [3:0] oe_max_ms(input logic [1:0] h, input logic [1:0] l);
		logic [3:0] s;
		s = oe_min_ms(h) + oe_min_ms(l);
		oe_max_ms = (s > 4'h5) ? s + 4'h2 : s + 4'h1;
	endfunction

	logic [8:0] cfg_q [NUM_CFG];
	logic [8:0] cfg_d [NUM_CFG];
	logic [8:0] status_w, rd_data;
	logic [2:0] rd_addr, sp_addr;
	logic [8:0] sp_wdata;
	logic sp_vld, sp_o, sp_oe;
	lfafe_cmd_t sp_cmd;

	logic [2:0] pick_q, pick_d, wake_q, wake_d, clamp_q, clamp_d, mod_q, mod_d;
	logic active_q, active_d, srst_q, srst_d, data_q, data_d, pin_q, pin_d, oe_q, oe_d;
	logic [IW-1:0] idle_q, idle_d;
	logic [PW-1:0] pre_q, pre_d;
	logic [3:0] ms_q, ms_d;
	logic [MW-1:0] pulse_q, pulse_d;
	lfafe_oef_t oef_q, oef_d;

	logic [2:0] en, gated;
	logic auto_on, ored, srst_now, idle_hit;
	logic [1:0] oeh, oel;

	lfafe_spi u_spi (
		.clk(clk),
		.rst(rst),
		.clk_en(clk_en),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdio_i(pin_i),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.cmd_valid(sp_vld),
		.cmd(sp_cmd),
		.addr(sp_addr),
		.wdata(sp_wdata),
		.sdio_o(sp_o),
		.sdio_oe(sp_oe)
	);

	// decoded configuration fields
	assign en = cfg_q[REG_CHAN][F_CHEN_HI:F_CHEN_LO];
	assign oeh = cfg_q[REG_CHAN][F_OEH_HI:F_OEH_LO];
	assign oel = cfg_q[REG_CHAN][F_OEL_HI:F_OEL_LO];
	assign auto_on = cfg_q[REG_AUTO][F_AUTO];

	// status word: pick X,Y,Z high bits, wake channels, odd row parity
	always_comb begin
		status_w = 9'h000;
		status_w[8:6] = pick_q;
		status_w[4:2] = wake_q;
		status_w[F_PARITY] = ~^status_w[8:1];
		rd_data = (rd_addr == REG_STATUS) ? status_w : cfg_q[rd_addr];
	end

	// register writes; the status index has no storage so writes drop
	always_comb begin
		for (int i = 0; i < NUM_CFG; i++) begin
			cfg_d[i] = cfg_q[i];
			if (sp_vld && sp_cmd == CMD_WRITE && sp_addr == 3'(i)) begin
				cfg_d[i] = sp_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q[0] <= RST_CHAN;
			for (int i = 1; i < NUM_CFG; i++) begin
				cfg_q[i] <= RST_CFG;
			end
		end else if (clk_en) begin
			cfg_q <= cfg_d;
		end
	end

	// soft reset from command or idle expiry; auto pick gating of data
	always_comb begin
		idle_hit = active_q && cs_n && (idle_q == IW'(IDLE_CYCLES - 1));
		srst_now = idle_hit || (sp_vld && sp_cmd == CMD_SOFT_RESET);
		gated = demod_ch & en;
		if (auto_on && output_type_select == OUT_DEMOD) begin
			gated = gated & pick_q;
		end
		ored = |gated;
	end

	// wake, pick, idle timer and clamp state
	always_comb begin
		active_d = active_q;
		pick_d = pick_q;
		wake_d = wake_q;
		clamp_d = clamp_q;
		idle_d = idle_q;
		pulse_d = pulse_q;
		data_d = ored;
		srst_d = srst_now;
		if (gain_settled && !active_q) begin
			active_d = 1'b1;
			wake_d = demod_ch & en;
			pick_d = auto_on ? demod_ch : 3'h7;
		end
		// any data edge or serial activity restarts the idle count
		if (!cs_n || ored != data_q || !active_q) begin
			idle_d = '0;
		end else begin
			idle_d = idle_q + IW'(1);
		end
		if (sp_vld && sp_cmd == CMD_CLAMP_ON) begin
			clamp_d = en;
		end
		if (sp_vld && sp_cmd == CMD_CLAMP_OFF) begin
			clamp_d = 3'h0;
		end
		if (pulse_q != '0) begin
			pulse_d = pulse_q - MW'(1);
		end
		if (srst_now) begin
			active_d = 1'b0;
			pick_d = 3'h7;
			wake_d = 3'h0;
			clamp_d = 3'h0;
			idle_d = '0;
			pulse_d = MW'(MOD_PULSE_CYCLES);
		end
		// next enable used so a disable releases its transistor on the same edge
		mod_d = (clamp_d & cfg_d[REG_CHAN][F_CHEN_HI:F_CHEN_LO]) | {3{pulse_d != '0}};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			active_q <= 1'b0;
			pick_q <= 3'h7;
			wake_q <= 3'h0;
			clamp_q <= 3'h0;
			idle_q <= '0;
			pulse_q <= '0;
			data_q <= 1'b0;
			srst_q <= 1'b0;
			mod_q <= 3'h0;
		end else if (clk_en) begin
			active_q <= active_d;
			pick_q <= pick_d;
			wake_q <= wake_d;
			clamp_q <= clamp_d;
			idle_q <= idle_d;
			pulse_q <= pulse_d;
			data_q <= data_d;
			srst_q <= srst_d;
			mod_q <= mod_d;
		end
	end

	// wake filter: high then low phase measured in ms ticks
	always_comb begin
		oef_d = oef_q;
		pre_d = pre_q + PW'(1);
		ms_d = ms_q;
		if (pre_q == PW'(MS_TICK_CYCLES - 1)) begin
			pre_d = '0;
			if (ms_q != 4'hf) begin
				ms_d = ms_q + 4'h1; // saturates; longest limit is ten
			end
		end
		unique case (oef_q)
			OEF_WAIT: begin
				if (active_q && oeh == 2'h0) begin
					oef_d = OEF_PASS;
				end else if (active_q && ored && !data_q) begin
					oef_d = OEF_HIGH;
				end
			end
			OEF_HIGH: begin
				if (ms_q > oe_max_ms(oeh, oel)) begin
					oef_d = OEF_WAIT;
				end else if (!ored) begin
					oef_d = (ms_q >= oe_min_ms(oeh)) ? OEF_LOW : OEF_WAIT;
				end
			end
			OEF_LOW: begin
				if (ms_q > oe_max_ms(oeh, oel)) begin
					oef_d = OEF_WAIT;
				end else if (ored) begin
					oef_d = (ms_q >= oe_min_ms(oel)) ? OEF_PASS : OEF_WAIT;
				end
			end
			OEF_PASS: oef_d = OEF_PASS;
		endcase
		if (oef_d != oef_q) begin
			pre_d = '0;
			ms_d = 4'h0;
		end
		if (srst_now || !active_q) begin
			oef_d = OEF_WAIT;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			oef_q <= OEF_WAIT;
			pre_q <= '0;
			ms_q <= 4'h0;
		end else if (clk_en) begin
			oef_q <= oef_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
		end
	end

	// shared pin: serial data while selected, else chosen output type
	always_comb begin
		if (!cs_n) begin
			pin_d = sp_o;
			oe_d = sp_oe;
		end else begin
			oe_d = 1'b1;
			unique case (output_type_select)
				OUT_CARRIER: pin_d = carrier_in;
				OUT_DEMOD: pin_d = ored && (oef_q == OEF_PASS);
				default: pin_d = 1'b0; // strength output leaves the pin low
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (clk_en) begin
			pin_q <= pin_d;
			oe_q <= oe_d;
		end
	end

	assign pin_o = pin_q;
	assign pin_oe = oe_q;
	assign modulation_on = mod_q;
	assign soft_reset_pulse = srst_q;
	assign channel_enable = en;
	assign output_type_select = cfg_q[REG_OUT][F_OUT_HI:F_OUT_LO];
	assign auto_channel_pick_enable = auto_on;
	assign tune_x = cfg_q[REG_OUT][F_TUNE_HI:F_TUNE_LO];
	assign tune_y = cfg_q[REG_TUNE_Y][F_TUNE_HI:F_TUNE_LO];
	assign tune_z = cfg_q[REG_TUNE_Z][F_TUNE_HI:F_TUNE_LO];
	assign sens_x = cfg_q[REG_SENS_XY][F_SENSA_HI:F_SENSA_LO];
	assign sens_y = cfg_q[REG_SENS_XY][F_SENSB_HI:F_SENSB_LO];
	assign sens_z = cfg_q[REG_AUTO][F_SENSA_HI - 1:F_SENSA_LO - 1];
endmodule // lfafe_ctrl

// File: bench/lfafe_ctrl_chk.sv
`timescale 1ns/100ps
module lfafe_ctrl_chk import lfafe_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic carrier_in,
	input wire logic [2:0] demod_ch,
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic [2:0] modulation_on,
	input wire logic [2:0] channel_enable,
	input wire logic [1:0] output_type_select,
	input wire logic auto_channel_pick_enable,
	input wire logic soft_reset_pulse
);
	logic [5:0] sr_q, sr_d;
	logic [2:0] cs_q, cs_d;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// age of last soft reset and last select; saturate so long runs stay quiet
	always_comb begin
		sr_d = (sr_q == 6'h3f) ? sr_q : sr_q + 6'h01;
		cs_d = (cs_q == 3'h7) ? cs_q : cs_q + 3'h1;
		if (soft_reset_pulse)
			sr_d = 6'h00;
		if (!cs_n)
			cs_d = 3'h0;
		if (rst) begin
			sr_d = 6'h3f;
			cs_d = 3'h7;
		end
	end
	always_ff @(posedge clk) begin
		sr_q <= sr_d;
		cs_q <= cs_d;
	end
	property p_sr_mod;
		soft_reset_pulse |-> ##[0:2] (modulation_on == 3'h7);
	endproperty
	a_sr_mod: assert property (p_sr_mod) else $error("no pulse on soft reset");
	property p_mod_en;
		|(modulation_on & ~channel_enable) |-> ##[0:2] (sr_q < 6'd45);
	endproperty
	a_mod_en: assert property (p_mod_en) else $error("disabled channel clamped");
	property p_mod_src;
		!$stable(modulation_on) |-> ##[0:2] (sr_q < 6'd45 || cs_q < 3'd5);
	endproperty
	a_mod_src: assert property (p_mod_src) else $error("clamp moved alone");
	property p_cfg_src;
		!$stable({channel_enable, auto_channel_pick_enable, output_type_select}) |-> cs_q < 3'd5;
	endproperty
	a_cfg_src: assert property (p_cfg_src) else $error("config moved alone");
	property p_oe;
		cs_n [*4] |-> pin_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("pin not driven");
	property p_rssi;
		(cs_n && output_type_select[1]) [*4] |-> !pin_o;
	endproperty
	a_rssi: assert property (p_rssi) else $error("pin busy in strength mode");
	property p_carrier;
		(cs_n && output_type_select == OUT_CARRIER && $stable(carrier_in)) [*4] |->
			pin_o == carrier_in;
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier not on pin");
	property p_zero;
		(cs_n && output_type_select == OUT_DEMOD && !(|(demod_ch & channel_enable))) [*4] |->
			!pin_o;
	endproperty
	a_zero: assert property (p_zero) else $error("data without channel");
endmodule // lfafe_ctrl_chk
bind lfafe_ctrl lfafe_ctrl_chk u_chk (.clk(clk), .rst(rst), .cs_n(cs_n),
	.carrier_in(carrier_in), .demod_ch(demod_ch), .pin_o(pin_o), .pin_oe(pin_oe),
	.modulation_on(modulation_on), .channel_enable(channel_enable),
	.output_type_select(output_type_select),
	.auto_channel_pick_enable(auto_channel_pick_enable),
	.soft_reset_pulse(soft_reset_pulse));

// File: bench/lfafe_mcu.sv
`timescale 1ns/100ps
module lfafe_mcu import lfafe_pkg::*; (
	input wire logic clk,
	input wire logic wire_i,
	output logic cs_n,
	output logic sclk,
	output logic sd
);
	localparam int HALF = 4; // one above the 3 clk minimum phase
	// idle: select high, serial clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sd = 1'b0;
	end
	// one frame, msb first, all changes on the falling clk edge
	task automatic xfer(input logic [2:0] c, input logic [2:0] a, input logic [8:0] d,
		output logic [8:0] rd);
		logic [14:0] f;
		f = {c, a, d};
		rd = 9'h000;
		@(negedge clk) cs_n = 1'b0;
		for (int i = 14; i >= 0; i--) begin
			sd = (c == CMD_READ && i < 9) ? ~sd : f[i]; // released line wanders
			repeat (HALF) @(negedge clk);
			sclk = 1'b1;
			repeat (HALF) @(negedge clk);
			// each read bit stands while sclk is high, from rise six on
			if (i > 0 && i < 10)
				rd[i-1] = wire_i;
			sclk = 1'b0;
		end
		repeat (HALF) @(negedge clk);
		cs_n = 1'b1;
		sd = ~sd;
	endtask
endmodule // lfafe_mcu

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench import lfafe_pkg::*;;
	logic clk, sclk, cs_n, sd, pin_w, pin_o, pin_oe, srp, ape;
	logic rst = 1'b1;
	logic carrier_in = 1'b0;
	logic gain_settled = 1'b0;
	logic [2:0] demod_ch = 3'h0;
	logic [2:0] mod_on, ch_en;
	logic [5:0] tx, ty, tz;
	logic [3:0] sx, sy, sz;
	logic [1:0] ots;
	logic [8:0] exq[$];
	logic [8:0] obs = 9'h000;
	logic [8:0] rv, s;
	logic obs_v = 1'b0;
	logic [31:0] rng = 32'h59c2;
	int miscompares = 0;
	int checks_done = 0;
	// shared pin: device wins while its enable is up
	assign pin_w = pin_oe ? pin_o : sd;
	lfafe_mcu u_mcu (.clk(clk), .wire_i(pin_w), .cs_n(cs_n), .sclk(sclk), .sd(sd));
	lfafe_ctrl #(.IDLE_CYCLES(200), .MS_TICK_CYCLES(20)) dut (
		.clk(clk), .rst(rst), .clk_en(1'b1), .cs_n(cs_n), .sclk(sclk), .pin_i(pin_w),
		.demod_ch(demod_ch), .carrier_in(carrier_in), .gain_settled(gain_settled),
		.pin_o(pin_o), .pin_oe(pin_oe), .modulation_on(mod_on), .channel_enable(ch_en),
		.tune_x(tx), .tune_y(ty), .tune_z(tz), .sens_x(sx), .sens_y(sy), .sens_z(sz),
		.output_type_select(ots), .auto_channel_pick_enable(ape), .soft_reset_pulse(srp));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic end_sim;
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// note the expectation, then hand the result to the watcher
	task automatic chk(input logic [8:0] e, input logic [8:0] g);
		exq.push_back(e);
		obs = g;
		obs_v = 1'b1;
		@(negedge clk) obs_v = 1'b0;
		@(negedge clk);
	endtask
	task automatic x(input logic [2:0] c, input logic [2:0] a, input logic [8:0] d);
		u_mcu.xfer(c, a, d, rv);
	endtask
	// oldest note against each reported result
	always @(posedge clk) begin
		if (obs_v) begin
			checks_done++;
			if (obs !== exq[0])
				$display("BAD t=%0t exp=%h got=%h", $time, exq[0], obs);
			if (obs !== exq[0])
				miscompares++;
			exq.delete(0);
		end
	end
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_sim;
	end
	initial begin
		logic [8:0] cfg [8];
		repeat (6) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 7; i++) begin
			x(CMD_READ, i[2:0], 9'h000);
			chk((i == 0) ? RST_CHAN : RST_CFG, rv);
		end
		x(CMD_READ, REG_STATUS, 9'h000);
		s = rv;
		chk(9'h1c0, s & 9'h1c0);
		// random contents; status must ignore the write
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			cfg[i] = (i == 7) ? s : rng[8:0];
			x(CMD_WRITE, i[2:0], rng[8:0]);
			x(CMD_READ, i[2:0], 9'h000);
			chk(cfg[i], rv);
		end
		chk({3'h0, cfg[1][6:1]}, {3'h0, tx});
		chk({3'h0, cfg[2][6:1]}, {3'h0, ty});
		chk({3'h0, cfg[3][6:1]}, {3'h0, tz});
		chk({1'b0, cfg[4][8:1]}, {1'b0, sx, sy});
		chk({cfg[5][7:4], cfg[5][8], cfg[1][8:7], 2'h0}, {sz, ape, ots, 2'h0});
		chk({cfg[0][8:6], 6'h0}, {ch_en, 6'h0});
		// clamp reaches enabled channels only
		x(CMD_WRITE, REG_CHAN, 9'h140);
		x(CMD_CLAMP_ON, 3'h0, 9'h000);
		chk(9'h005, {6'h0, mod_on});
		x(CMD_WRITE, REG_CHAN, 9'h100);
		chk(9'h004, {6'h0, mod_on});
		x(CMD_CLAMP_OFF, 3'h0, 9'h000);
		chk(9'h000, {6'h0, mod_on});
		x(CMD_SOFT_RESET, 3'h0, 9'h000);
		chk(9'h007, {6'h0, mod_on});
		repeat (40) @(negedge clk);
		chk(9'h000, {6'h0, mod_on});
		// auto pick on demodulated data, filter off
		x(CMD_WRITE, REG_CHAN, RST_CHAN);
		x(CMD_WRITE, REG_OUT, 9'h000);
		x(CMD_WRITE, REG_AUTO, 9'h100);
		demod_ch = 3'h5;
		gain_settled = 1'b1;
		@(negedge clk) gain_settled = 1'b0;
		x(CMD_READ, REG_STATUS, 9'h000);
		chk(9'h140, rv & 9'h1c0);
		repeat (3) @(negedge clk);
		chk(9'h001, {8'h0, pin_o});
		demod_ch = 3'h2;
		repeat (3) @(negedge clk);
		chk(9'h000, {8'h0, pin_o});
		// carrier ignores the blocked channel
		x(CMD_WRITE, REG_OUT, 9'h080);
		for (int k = 0; k < 6; k++) begin
			carrier_in = k[0];
			repeat (4) @(negedge clk);
			chk({8'h0, carrier_in}, {8'h0, pin_o});
		end
		x(CMD_WRITE, REG_OUT, 9'h000);
		// quiet input times out and clears the pick
		for (int n = 0; n < 400 && srp !== 1'b1; n++)
			@(negedge clk);
		chk(9'h001, {8'h0, srp});
		x(CMD_READ, REG_STATUS, 9'h000);
		chk(9'h1c0, rv & 9'h1c0);
		// wake filter: one ms high then one ms low before data passes
		x(CMD_WRITE, REG_AUTO, 9'h000);
		x(CMD_WRITE, REG_CHAN, 9'h1d4);
		demod_ch = 3'h0;
		gain_settled = 1'b1;
		@(negedge clk) gain_settled = 1'b0;
		demod_ch = 3'h7;
		repeat (30) @(negedge clk);
		chk(9'h000, {8'h0, pin_o});
		demod_ch = 3'h0;
		repeat (30) @(negedge clk);
		demod_ch = 3'h7;
		repeat (4) @(negedge clk);
		chk(9'h001, {8'h0, pin_o});
		end_sim;
	end
endmodule // testbench
